// ==== src/ccp_pwm_pkg.sv ====
// Constants and types shared by the capture/compare/PWM block
package ccp_pwm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOW = 8'h04;
  localparam logic [7:0] OFF_HIGH = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FMT_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_DRV_BIT = 4;
  // Status field positions
  localparam int STAT_CAP_BIT = 0;
  localparam int STAT_CMP_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_RES_LSB = 4;
  localparam int STAT_DUTY_LSB = 8;
  // Count readback field positions
  localparam int CNT_PRESC_LSB = 0;
  localparam int CNT_COUNT_LSB = 2;
  // Reset values and the prescaler's last count
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  // Modes
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_PWM = 2'b11
  } ccp_mode_e;
  // Period timer plus its two prescale bits
  typedef struct packed {
    logic [7:0] count;
    logic [1:0] presc;
  } timebase_s;
endpackage

// ==== src/ccp_timebase.sv ====
// Period timer with two-bit prescaler, clocked from the system clock
`timescale 1ns/10ps
`default_nettype none
module ccp_timebase (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [7:0] limit_in,
  output var ccp_pwm_pkg::timebase_s tb_out,
  output logic period_end_out
);
  ccp_pwm_pkg::timebase_s tb_q, tb_d;

  always_comb begin
    tb_d = tb_q;
    if (clear_in) begin
      tb_d = '0;
    end else if (run_in) begin
      tb_d.presc = tb_q.presc + 2'h1;
      if (tb_q.presc == ccp_pwm_pkg::PRESC_LAST) begin
        if (tb_q.count == limit_in) begin
          tb_d.count = 8'h00;
        end else begin
          tb_d.count = tb_q.count + 8'h01;
        end
      end
    end
    // Not running: hold, so a wake resumes where sleep left off
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tb_q <= '0;
    end else begin
      tb_q <= tb_d;
    end
  end

  assign tb_out = tb_q;
  assign period_end_out = run_in && !clear_in &&
    tb_q.presc == ccp_pwm_pkg::PRESC_LAST && tb_q.count == limit_in;
endmodule // ccp_timebase
`default_nettype wire

// ==== src/ccp_pwm_duty_resolution.sv ====
// Capture/compare/PWM unit with APB register access
`timescale 1ns/10ps
`default_nettype none
module ccp_pwm_duty_resolution (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sleep_in,
  input wire logic capture_pin_in,
  input wire logic [15:0] capture_timebase_count_in,
  output logic compare_match_out,
  output logic pwm_output_pin_out,
  output logic pwm_output_pin_oe_n_out
);
  typedef struct packed {
    ccp_pwm_pkg::ccp_mode_e mode;
    logic fmt;
    logic en;
    logic drive;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] limit;
    logic cap_flag;
    logic cmp_flag;
    logic [9:0] duty;
    logic duty_ok;
    logic pin;
    logic oe_n;
    logic run;
    logic cmp_match;
    logic [1:0] cap_sync;
    logic cap_prev;
    logic [1:0] sleep_sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s st_q, st_d;
  ccp_pwm_pkg::timebase_s tb;
  logic period_end;
  logic sleeping;
  logic active;
  logic cap_evt;
  logic cmp_hit;
  logic boundary;
  logic [9:0] duty_new;
  logic [9:0] ext;
  logic [10:0] len;
  logic setup;
  logic wr;
  logic mapped;

  function automatic logic [10:0] period_len(input logic [7:0] lim);
    logic [8:0] p1;
    p1 = {1'b0, lim} + 9'd1;
    return {p1, 2'b00};
  endfunction

  // Floor log2: a fractional resolution reads back with its fraction dropped
  function automatic logic [3:0] res_bits(input logic [10:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == ccp_pwm_pkg::OFF_CTRL || a == ccp_pwm_pkg::OFF_LOW ||
      a == ccp_pwm_pkg::OFF_HIGH || a == ccp_pwm_pkg::OFF_LIMIT ||
      a == ccp_pwm_pkg::OFF_STATUS || a == ccp_pwm_pkg::OFF_COUNT;
  endfunction

  ccp_timebase u_timebase (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    // Held in the start cycle so the first period is as long as the rest
    .run_in(active && !sleeping && st_q.run),
    .clear_in(!active),
    .limit_in(st_q.limit),
    .tb_out(tb),
    .period_end_out(period_end)
  );

  always_comb begin
    sleeping = st_q.sleep_sync[1];
    active = st_q.mode == ccp_pwm_pkg::MODE_PWM && st_q.en;
    if (st_q.fmt) begin
      duty_new = {st_q.high, st_q.low[7:6]};
    end else begin
      duty_new = {st_q.high[1:0], st_q.low};
    end
    ext = {tb.count, tb.presc};
    len = period_len(st_q.limit);
    cap_evt = st_q.mode == ccp_pwm_pkg::MODE_CAPTURE && st_q.en && !sleeping &&
      st_q.cap_sync[1] && !st_q.cap_prev;
    cmp_hit = st_q.mode == ccp_pwm_pkg::MODE_COMPARE && st_q.en && !sleeping &&
      capture_timebase_count_in == {st_q.high, st_q.low};
    boundary = period_end || (active && !sleeping && !st_q.run);
    setup = psel_in && !penable_in;
    wr = psel_in && penable_in && st_q.pready && pwrite_in;
    mapped = is_mapped(paddr_in);
  end

  always_comb begin
    st_d = st_q;
    st_d.cap_sync = {st_q.cap_sync[0], capture_pin_in};
    st_d.sleep_sync = {st_q.sleep_sync[0], sleep_in};
    st_d.cap_prev = st_q.cap_sync[1];
    st_d.cmp_match = cmp_hit;
    st_d.pready = setup;
    st_d.pslverr = setup && !mapped;
    // Register writes land at the access edge
    if (wr) begin
      case (paddr_in)
        ccp_pwm_pkg::OFF_CTRL: begin
          st_d.mode = ccp_pwm_pkg::ccp_mode_e'(pwdata_in[ccp_pwm_pkg::CTRL_MODE_LSB +: 2]);
          st_d.fmt = pwdata_in[ccp_pwm_pkg::CTRL_FMT_BIT];
          st_d.en = pwdata_in[ccp_pwm_pkg::CTRL_EN_BIT];
          st_d.drive = pwdata_in[ccp_pwm_pkg::CTRL_DRV_BIT];
        end
        ccp_pwm_pkg::OFF_LOW: st_d.low = pwdata_in[7:0];
        ccp_pwm_pkg::OFF_HIGH: st_d.high = pwdata_in[7:0];
        ccp_pwm_pkg::OFF_LIMIT: st_d.limit = pwdata_in[7:0];
        ccp_pwm_pkg::OFF_STATUS: begin
          if (pwdata_in[ccp_pwm_pkg::STAT_CAP_BIT]) begin
            st_d.cap_flag = 1'b0;
          end
          if (pwdata_in[ccp_pwm_pkg::STAT_CMP_BIT]) begin
            st_d.cmp_flag = 1'b0;
          end
        end
        default: st_d.low = st_q.low;
      endcase
    end
    st_d.oe_n = !(st_d.drive && st_d.en && st_d.mode == ccp_pwm_pkg::MODE_PWM);
    // Hardware events after the write so a same-cycle set beats a clear
    if (cap_evt) begin
      st_d.high = capture_timebase_count_in[15:8];
      st_d.low = capture_timebase_count_in[7:0];
      st_d.cap_flag = 1'b1;
    end
    if (cmp_hit) begin
      st_d.cmp_flag = 1'b1;
    end
    // PWM output, frozen while asleep
    if (!active) begin
      st_d.pin = 1'b0;
      st_d.run = 1'b0;
      st_d.duty = duty_new;
      st_d.duty_ok = {1'b0, duty_new} <= len;
    end else if (!sleeping) begin
      st_d.run = 1'b1;
      if (boundary) begin
        st_d.duty = duty_new;
        st_d.duty_ok = {1'b0, duty_new} <= len;
        if ({1'b0, duty_new} <= len) begin
          st_d.pin = duty_new != 10'h000;
        end
        // Width beyond the period: pin keeps its level
      end else if (st_q.duty_ok && ext + 10'h001 >= st_q.duty) begin
        st_d.pin = 1'b0;
      end
    end
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      case (paddr_in)
        ccp_pwm_pkg::OFF_CTRL: begin
          st_d.prdata[ccp_pwm_pkg::CTRL_MODE_LSB +: 2] = st_q.mode;
          st_d.prdata[ccp_pwm_pkg::CTRL_FMT_BIT] = st_q.fmt;
          st_d.prdata[ccp_pwm_pkg::CTRL_EN_BIT] = st_q.en;
          st_d.prdata[ccp_pwm_pkg::CTRL_DRV_BIT] = st_q.drive;
        end
        ccp_pwm_pkg::OFF_LOW: st_d.prdata[7:0] = st_q.low;
        ccp_pwm_pkg::OFF_HIGH: st_d.prdata[7:0] = st_q.high;
        ccp_pwm_pkg::OFF_LIMIT: st_d.prdata[7:0] = st_q.limit;
        ccp_pwm_pkg::OFF_STATUS: begin
          st_d.prdata[ccp_pwm_pkg::STAT_CAP_BIT] = st_q.cap_flag;
          st_d.prdata[ccp_pwm_pkg::STAT_CMP_BIT] = st_q.cmp_flag;
          st_d.prdata[ccp_pwm_pkg::STAT_PIN_BIT] = st_q.pin;
          st_d.prdata[ccp_pwm_pkg::STAT_SLEEP_BIT] = sleeping;
          st_d.prdata[ccp_pwm_pkg::STAT_RES_LSB +: 4] = res_bits(len);
          st_d.prdata[ccp_pwm_pkg::STAT_DUTY_LSB +: 10] = st_q.duty;
        end
        ccp_pwm_pkg::OFF_COUNT: begin
          st_d.prdata[ccp_pwm_pkg::CNT_PRESC_LSB +: 2] = tb.presc;
          st_d.prdata[ccp_pwm_pkg::CNT_COUNT_LSB +: 8] = tb.count;
        end
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.high <= ccp_pwm_pkg::CCR_RST;
      st_q.low <= ccp_pwm_pkg::CCR_RST;
      st_q.limit <= ccp_pwm_pkg::LIMIT_RST;
      st_q.oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_out = st_q.prdata;
  assign pready_out = st_q.pready;
  assign pslverr_out = st_q.pslverr;
  assign compare_match_out = st_q.cmp_match;
  assign pwm_output_pin_out = st_q.pin;
  // Low enables the driver; reset leaves the pin an input
  assign pwm_output_pin_oe_n_out = st_q.oe_n;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_capture_high_load: assert property (
    cap_evt |=> st_q.high == $past(capture_timebase_count_in[15:8]))
    else $error("capture did not load high byte");

  a_compare_match_pulse: assert property (
    (st_q.mode == ccp_pwm_pkg::MODE_COMPARE && st_q.en && !sleeping &&
     capture_timebase_count_in == {st_q.high, st_q.low}) |=> compare_match_out)
    else $error("compare match missed");

  a_right_align_width: assert property (
    (active && !sleeping && boundary && !st_q.fmt) |=>
      st_q.duty == {$past(st_q.high[1:0]), $past(st_q.low)})
    else $error("right aligned width wrong");

  a_left_align_width: assert property (
    (active && !sleeping && boundary && st_q.fmt) |=>
      st_q.duty[9:2] == $past(st_q.high))
    else $error("left aligned width wrong");

  a_resolution_max: assert property (
    st_q.limit == 8'hff |-> res_bits(len) == 4'd10)
    else $error("resolution not ten bits at full limit");

  a_wide_pulse_hold: assert property (
    (active && !sleeping && boundary && {1'b0, duty_new} > len) |=>
      $stable(pwm_output_pin_out) ##1 $stable(pwm_output_pin_out))
    else $error("pin moved with width above period");

  a_sleep_count_hold: assert property (
    (sleeping && active) [*3] |=> $stable(tb) && $stable(st_q.duty))
    else $error("timer moved during sleep");

  a_sleep_pin_hold: assert property (
    (sleeping && active && $past(sleeping)) |-> $stable(pwm_output_pin_out))
    else $error("pin changed during sleep");

  a_wake_resume_count: assert property (
    (active && sleeping ##1 active && !sleeping) |-> tb == $past(tb))
    else $error("count reloaded on wake");

  a_reset_pin_input: assert property (
    $past(rst_in) |-> pwm_output_pin_oe_n_out && !st_q.drive)
    else $error("pin not input after reset");

  a_pwm_fall_width: assert property (
    (active && !sleeping && st_q.run && !boundary && st_q.duty_ok &&
     ext + 10'h001 >= st_q.duty) |=> !pwm_output_pin_out)
    else $error("output did not fall at width");

  a_width_latch_boundary: assert property (
    (active && !boundary && st_q.run) |=> $stable(st_q.duty))
    else $error("width changed mid period");
endmodule // ccp_pwm_duty_resolution
`default_nettype wire

// ==== dv/pwm_load_model.sv ====
// External load on the PWM pin: times each high pulse it sees
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
  input wire logic clk_in,
  input wire logic pin_in,
  input wire logic oe_n_in,
  output logic pulse_done_out,
  output logic [15:0] pulse_len_out
);
  logic line;
  logic [15:0] hi_cnt = 16'h0000;
  // Undriven pin is pulled down by the load, so no stale level is seen
  assign line = !oe_n_in && pin_in;
  initial pulse_done_out = 1'b0;
  initial pulse_len_out = 16'h0000;
  always @(posedge clk_in) begin
    pulse_done_out <= 1'b0;
    if (line) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end else if (hi_cnt != 16'h0000) begin
      pulse_done_out <= 1'b1;
      pulse_len_out <= hi_cnt;
      hi_cnt <= 16'h0000;
    end
  end
endmodule // pwm_load_model
`default_nettype wire

// ==== dv/ccp_pwm_duty_resolution_tb.sv ====
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/10ps
`default_nettype none
module ccp_pwm_duty_resolution_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, cap_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] hi, lo;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] cap_cnt = 16'h0000;
  logic [31:0] prdata, rd, c1;
  logic pready, pslverr, cmp_match, pin, oe_n, done, err;
  logic [15:0] plen;
  logic [15:0] exp_q[$];
  int fails = 0, tests_run = 0, cyc = 0, last = 0, per = 0;

  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;

  ccp_pwm_duty_resolution dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sleep_in(sleep),
    .capture_pin_in(cap_pin), .capture_timebase_count_in(cap_cnt),
    .compare_match_out(cmp_match), .pwm_output_pin_out(pin), .pwm_output_pin_oe_n_out(oe_n));
  pwm_load_model load (.clk_in(clk_sys_in), .pin_in(pin), .oe_n_in(oe_n),
    .pulse_done_out(done), .pulse_len_out(plen));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(nm, rd, exp);
  endtask

  // Waits until only k expected pulses remain
  task automatic wait_q(input int k);
    int n;
    n = 0;
    while (exp_q.size() > k && n < 5000) begin
      @(posedge clk_sys_in);
      n++;
    end
    check("pending pulses", exp_q.size(), k);
  endtask

  task automatic run(input logic [7:0] ctl, input logic [7:0] lim, input logic [15:0] w);
    per = 4 * (int'(lim) + 1);
    last = 0;
    apb(1'b1, ccp_pwm_pkg::OFF_LIMIT, {24'h000000, lim});
    apb(1'b1, ccp_pwm_pkg::OFF_HIGH, {24'h000000, hi});
    apb(1'b1, ccp_pwm_pkg::OFF_LOW, {24'h000000, lo});
    exp_q.push_back(w);
    exp_q.push_back(w);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, {24'h000000, ctl});
    wait_q(0);
    // Disable right after a fall, while the pin is low
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h00000000);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check("unplanned pulse", {16'h0000, plen}, 0);
      else check("pulse width", {16'h0000, plen}, {16'h0000, exp_q.pop_front()});
      // Pulse starts are spaced by the period whatever the widths
      if (per != 0 && last != 0) check("period", cyc - int'(plen) - last, per);
      last <= cyc - int'(plen);
    end
  end

  initial begin
    #(20 * 40000);
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(39));
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("oe_n", {31'h0, oe_n}, 1);
    rdchk("ctrl", ccp_pwm_pkg::OFF_CTRL, 0);
    rdchk("high", ccp_pwm_pkg::OFF_HIGH, {24'h0, ccp_pwm_pkg::CCR_RST});
    rdchk("limit", ccp_pwm_pkg::OFF_LIMIT, {24'h0, ccp_pwm_pkg::LIMIT_RST});
    apb(1'b0, 8'h18, 32'h00000000);
    check("slverr", {31'h0, err}, 1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ccp_pwm_pkg::OFF_LIMIT, (i == 0) ? 32'h03 : (i == 1) ? 32'h3f : 32'hff);
      apb(1'b0, ccp_pwm_pkg::OFF_STATUS, 32'h00000000);
      check("resolution", rd[7:4], (i == 0) ? 4 : (i == 1) ? 8 : 10);
    end
    // Random upper bits must be ignored in right-aligned format
    hi = 8'($urandom) & 8'hfd;
    lo = 8'($urandom_range(200, 1));
    run(8'h1b, 8'hff, {6'h00, hi[1:0], lo});
    hi = 8'($urandom_range(100, 1));
    lo = 8'($urandom);
    run(8'h1f, 8'hff, {6'h00, hi, lo[7:6]});
    // New width written mid-pulse must wait for the next period
    hi = 8'h00;
    lo = 8'h40;
    per = 1024;
    last = 0;
    exp_q.push_back(16'd64);
    exp_q.push_back(16'd32);
    apb(1'b1, ccp_pwm_pkg::OFF_HIGH, 32'h00000000);
    apb(1'b1, ccp_pwm_pkg::OFF_LOW, 32'h00000040);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h0000001b);
    while (pin !== 1'b1 && cyc < 30000) @(posedge clk_sys_in);
    apb(1'b1, ccp_pwm_pkg::OFF_LOW, 32'h00000020);
    wait_q(0);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h00000000);
    // Sleep between pulses; period check off since sleep stretches it
    per = 0;
    exp_q.push_back(16'd32);
    exp_q.push_back(16'd32);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h0000001b);
    wait_q(1);
    sleep <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, ccp_pwm_pkg::OFF_COUNT, 32'h00000000);
    c1 = rd;
    repeat (50) @(posedge clk_sys_in);
    rdchk("frozen count", ccp_pwm_pkg::OFF_COUNT, c1);
    check("drive in sleep", {30'h0, oe_n, pin}, 0);
    sleep <= 1'b0;
    // Let the wake pass the synchroniser before sampling the count
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, ccp_pwm_pkg::OFF_COUNT, 32'h00000000);
    check("resume", {31'h0, rd[9:0] > c1[9:0] && rd[9:0] - c1[9:0] < 10'd40}, 1);
    wait_q(0);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h00000000);
    // Width 32 against a 16-clock period: no pulse at all
    apb(1'b1, ccp_pwm_pkg::OFF_LIMIT, 32'h00000003);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h0000001b);
    repeat (60) @(posedge clk_sys_in);
    check("pin held", {31'h0, pin}, 0);
    cap_cnt <= 16'($urandom);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h00000009);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rdchk("captured high", ccp_pwm_pkg::OFF_HIGH, {24'h0, cap_cnt[15:8]});
    cap_pin <= 1'b0;
    hi = 8'($urandom);
    apb(1'b1, ccp_pwm_pkg::OFF_HIGH, {24'h0, hi});
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h0000000a);
    cap_cnt <= {hi, cap_cnt[7:0]};
    repeat (3) @(posedge clk_sys_in);
    check("match", {31'h0, cmp_match}, 1);
    cap_cnt <= {~hi, cap_cnt[7:0]};
    repeat (3) @(posedge clk_sys_in);
    check("no match", {31'h0, cmp_match}, 0);
    apb(1'b1, ccp_pwm_pkg::OFF_CTRL, 32'h0000001b);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("oe_n after reset", {31'h0, oe_n}, 1);
    rdchk("limit after reset", ccp_pwm_pkg::OFF_LIMIT, 32'h000000ff);
    tally_and_finish();
  end
endmodule // ccp_pwm_duty_resolution_tb
`default_nettype wire
